/* design/cotrp_pkg.sv */
// package: register map, field layout, reset values, states and timing counts
`default_nettype none

package cotrp_pkg;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] COTRP_LOW_OFS = 8'h32;
  localparam logic [7:0] COTRP_HIGH_OFS = 8'h33;
  localparam logic [7:0] COTRP_LOW_RST = 8'hB7;
  localparam logic [7:0] COTRP_HIGH_RST = 8'h00;

  // ----------------------------------------------------------------
  // high byte fields
  // ----------------------------------------------------------------
  localparam int unsigned COTRP_HI_DEG_LSB = 6;
  localparam int unsigned COTRP_HI_IIN_BIT = 5;
  localparam int unsigned COTRP_HI_VSYS_BIT = 4;
  localparam int unsigned COTRP_HI_OVLD_BIT = 3;
  localparam int unsigned COTRP_HI_RELAX_BIT = 2;
  localparam int unsigned COTRP_HI_TMAX_LSB = 0;

  // ----------------------------------------------------------------
  // low byte fields
  // ----------------------------------------------------------------
  localparam int unsigned COTRP_LO_EXT_BIT = 7;
  localparam int unsigned COTRP_LO_MON_BIT = 6;
  localparam int unsigned COTRP_LO_LSW_BIT = 5;
  localparam int unsigned COTRP_LO_FIX_BIT = 4;
  localparam int unsigned COTRP_LO_IOC_EN_BIT = 3;
  localparam int unsigned COTRP_LO_IOC_LVL_BIT = 2;
  localparam int unsigned COTRP_LO_DOC_EN_BIT = 1;
  localparam int unsigned COTRP_LO_DOC_LVL_BIT = 0;

  // ----------------------------------------------------------------
  // synchroniser lanes of the pin inputs
  // ----------------------------------------------------------------
  localparam int unsigned COTRP_SYN_ADAPTER = 0;
  localparam int unsigned COTRP_SYN_OVERSHOOT = 1;
  localparam int unsigned COTRP_SYN_UNDERSHOOT = 2;
  localparam int unsigned COTRP_SYN_FIXED = 3;
  localparam int unsigned COTRP_SYN_INPUT_OC = 4;
  localparam int unsigned COTRP_SYN_DISCHARGE = 5;
  localparam int unsigned COTRP_SYN_W = 6;

  // ----------------------------------------------------------------
  // times as printed, and their cycle counts at the reference clock
  // ----------------------------------------------------------------
  localparam int unsigned COTRP_CLK_MHZ = 200;
  localparam int unsigned COTRP_DEG0_US = 1000;
  localparam int unsigned COTRP_DEG1_US = 2000;
  localparam int unsigned COTRP_DEG2_US = 5000;
  localparam int unsigned COTRP_DEG3_US = 10000;
  localparam int unsigned COTRP_TMAX0_MS = 20;
  localparam int unsigned COTRP_TMAX1_MS = 40;
  localparam int unsigned COTRP_TMAX2_MS = 80;
  localparam int unsigned COTRP_TMAX3_MS = 1000;
  localparam int unsigned COTRP_IOC_BLANK_US = 250;
  localparam int unsigned COTRP_IOC_RESUME_MS = 250;

  localparam int unsigned COTRP_DEG0_CYC = COTRP_DEG0_US * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_DEG1_CYC = COTRP_DEG1_US * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_DEG2_CYC = COTRP_DEG2_US * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_DEG3_CYC = COTRP_DEG3_US * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_TMAX0_CYC = COTRP_TMAX0_MS * 1000 * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_TMAX1_CYC = COTRP_TMAX1_MS * 1000 * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_TMAX2_CYC = COTRP_TMAX2_MS * 1000 * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_TMAX3_CYC = COTRP_TMAX3_MS * 1000 * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_IOC_BLANK_CYC = COTRP_IOC_BLANK_US * COTRP_CLK_MHZ;
  localparam int unsigned COTRP_IOC_RESUME_CYC = COTRP_IOC_RESUME_MS * 1000 * COTRP_CLK_MHZ;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    COTRP_PP_IDLE  = 2'b00,
    COTRP_PP_QUAL  = 2'b01,
    COTRP_PP_OVLD  = 2'b10,
    COTRP_PP_RELAX = 2'b11
  } cotrp_pp_e;

  typedef enum logic [1:0] {
    COTRP_OC_OK     = 2'b00,
    COTRP_OC_BLANK  = 2'b01,
    COTRP_OC_OFF    = 2'b10,
    COTRP_OC_RESUME = 2'b11
  } cotrp_oc_e;

endpackage : cotrp_pkg

`default_nettype wire

/* design/cotrp_span_timer.sv */
// cycle timer: expires after limit_i cycles of uninterrupted run
`default_nettype none

module cotrp_span_timer #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic             ref_clk_i, // reference clock
  input  wire logic             rst_i,     // synchronous reset, high
  input  wire logic             restart_i, // zero the count this cycle
  input  wire logic             run_i,     // count while high
  input  wire logic [CNT_W-1:0] limit_i,   // cycles to expiry, at least 1
  output logic                  expired_o  // high once limit reached
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             expired;
  } cotrp_tmr_s;

  cotrp_tmr_s r_reg;
  cotrp_tmr_s r_next;

  always_comb begin
    r_next = r_reg;
    if (restart_i || !run_i) begin
      r_next.count   = '0;
      r_next.expired = 1'b0;
    end else if (!r_reg.expired) begin
      // saturate rather than wrap so a held run never re-arms
      if (CNT_W'(r_reg.count + 1'b1) >= limit_i) begin
        r_next.expired = 1'b1;
      end else begin
        r_next.count = CNT_W'(r_reg.count + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign expired_o = r_reg.expired;

endmodule : cotrp_span_timer

`default_nettype wire

/* design/cotrp_regs.sv */
// charger option two register pair: peak power control and overcurrent options
//
// Function
// - overload deglitch code picks 1, 2, 5 or 10 ms before overload cycle.
// - input-overshoot enable lets an input current overshoot start peak power.
// - system-undershoot enable lets a system voltage dip start peak power.
// - with both trigger enables clear, peak power mode stays off.
// - adapter removal clears both trigger enables by hardware.
// - overload flag reads 1 in overload cycle; writing 0 leaves it.
// - relax flag reads 1 in relax cycle; writing 0 leaves it.
// - cycle time code picks 20, 40, 80 ms or 1 s per cycle.
// - external limit select takes the lower of pin and register limit.
// - monitor select reports discharge current at 0, charge at 1.
// - low-side switch trip select picks 210 mV or 150 mV.
// - fixed input trip stops switching at once, resumes on release.
// - enabled input overcurrent stops after blanking, restarts after 250 ms clear.
// - input overcurrent level select picks 133% or 200% of second limit.
// - enabled discharge overcurrent trip disables the converter.
// - discharge level select picks 133% or 200% of second discharge limit.
`default_nettype none

module cotrp_regs
  import cotrp_pkg::*;
#(
  parameter int unsigned LIM_W           = 8,
  parameter int unsigned DEG_CYC_0       = COTRP_DEG0_CYC,
  parameter int unsigned DEG_CYC_1       = COTRP_DEG1_CYC,
  parameter int unsigned DEG_CYC_2       = COTRP_DEG2_CYC,
  parameter int unsigned DEG_CYC_3       = COTRP_DEG3_CYC,
  parameter int unsigned TMAX_CYC_0      = COTRP_TMAX0_CYC,
  parameter int unsigned TMAX_CYC_1      = COTRP_TMAX1_CYC,
  parameter int unsigned TMAX_CYC_2      = COTRP_TMAX2_CYC,
  parameter int unsigned TMAX_CYC_3      = COTRP_TMAX3_CYC,
  parameter int unsigned IOC_BLANK_CYC   = COTRP_IOC_BLANK_CYC,
  parameter int unsigned IOC_RESUME_CYC  = COTRP_IOC_RESUME_CYC
) (
  input  wire logic             ref_clk_i,                       // 200 MHz clock
  input  wire logic             rst_i,                           // sync reset, high
  // register port from the serial bus engine
  input  wire logic [7:0]       reg_addr_i,                      // register address
  input  wire logic             reg_wr_i,                        // write strobe
  input  wire logic [7:0]       reg_wdata_i,                     // write data
  input  wire logic             reg_rd_i,                        // read strobe
  output logic [7:0]            reg_rdata_o,                     // read data, next cycle
  // pin and comparator inputs, asynchronous
  input  wire logic             adapter_present_i,               // adapter attached
  input  wire logic             input_overshoot_i,               // input current overshoot
  input  wire logic             system_undershoot_i,             // system voltage dip
  input  wire logic             fixed_input_trip_i,              // fixed input comparator
  input  wire logic             input_overcurrent_trip_i,        // configurable input comp.
  input  wire logic             discharge_overcurrent_trip_i,    // battery discharge comp.
  // limit values from the same clock domain
  input  wire logic [LIM_W-1:0] limit_setting_pin_i,             // pin limit, digitised
  input  wire logic [LIM_W-1:0] input_limit_value_i,             // input limit register
  // outputs
  output logic [LIM_W-1:0]      input_limit_o,                   // effective input limit
  output logic                  converter_enable_o,              // converter may switch
  output logic                  overload_cycle_o,                // in overload cycle
  output logic                  relax_cycle_o,                   // in relax cycle
  output logic                  battery_monitor_direction_sel_o, // 1 = charge current
  output logic                  low_side_switch_trip_sel_o,      // 1 = 150 mV
  output logic                  fixed_input_trip_sel_o,          // 1 = lower level
  output logic                  input_overcurrent_level_sel_o,   // 1 = 200 %
  output logic                  discharge_overcurrent_level_sel_o // 1 = 200 %
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COTRP_SYN_W-1:0] sync1;
    logic [COTRP_SYN_W-1:0] sync2;
    logic                   adapter_prev;
    logic [7:0]             low;
    logic [1:0]             deg;
    logic                   en_iin;
    logic                   en_vsys;
    logic [1:0]             tmax;
    cotrp_pp_e              pp;
    cotrp_oc_e              oc;
    logic                   conv_en;
    logic [LIM_W-1:0]       limit;
    logic [7:0]             rdata;
  } cotrp_state_s;

  cotrp_state_s r_reg;
  cotrp_state_s r_next;

  logic        pp_restart;
  logic        pp_run;
  logic [31:0] pp_limit;
  logic        pp_done;
  logic        oc_restart;
  logic        oc_run;
  logic [31:0] oc_limit;
  logic        oc_done;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  cotrp_span_timer #(
    .CNT_W     (32)
  ) u_pp_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .restart_i (pp_restart),
    .run_i     (pp_run),
    .limit_i   (pp_limit),
    .expired_o (pp_done)
  );

  cotrp_span_timer #(
    .CNT_W     (32)
  ) u_oc_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .restart_i (oc_restart),
    .run_i     (oc_run),
    .limit_i   (oc_limit),
    .expired_o (oc_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic hi_wr;
    logic lo_wr;
    logic removal;
    logic trig;
    logic clr_ovld;
    logic clr_relax;
    logic ioc_trip;
    logic doc_trip;
    hi_wr     = reg_wr_i && (reg_addr_i == COTRP_HIGH_OFS);
    lo_wr     = reg_wr_i && (reg_addr_i == COTRP_LOW_OFS);
    removal   = r_reg.adapter_prev && !r_reg.sync2[COTRP_SYN_ADAPTER];
    clr_ovld  = hi_wr && !reg_wdata_i[COTRP_HI_OVLD_BIT];
    clr_relax = hi_wr && !reg_wdata_i[COTRP_HI_RELAX_BIT];
    trig      = (r_reg.en_iin && r_reg.sync2[COTRP_SYN_OVERSHOOT])
             || (r_reg.en_vsys && r_reg.sync2[COTRP_SYN_UNDERSHOOT]);
    ioc_trip  = r_reg.low[COTRP_LO_IOC_EN_BIT] && r_reg.sync2[COTRP_SYN_INPUT_OC];
    doc_trip  = r_reg.low[COTRP_LO_DOC_EN_BIT] && r_reg.sync2[COTRP_SYN_DISCHARGE];

    r_next = r_reg;

    // pins pass two flops before any logic reads them
    r_next.sync1 = {discharge_overcurrent_trip_i, input_overcurrent_trip_i,
                    fixed_input_trip_i, system_undershoot_i,
                    input_overshoot_i, adapter_present_i};
    r_next.sync2 = r_reg.sync1;
    r_next.adapter_prev = r_reg.sync2[COTRP_SYN_ADAPTER];

    // register writes; status bits only accept a zero, handled below
    if (lo_wr) begin
      r_next.low = reg_wdata_i;
    end
    if (hi_wr) begin
      r_next.deg     = reg_wdata_i[COTRP_HI_DEG_LSB +: 2];
      r_next.en_iin  = reg_wdata_i[COTRP_HI_IIN_BIT];
      r_next.en_vsys = reg_wdata_i[COTRP_HI_VSYS_BIT];
      r_next.tmax    = reg_wdata_i[COTRP_HI_TMAX_LSB +: 2];
    end
    // removal beats a host write in the same cycle
    if (removal) begin
      r_next.en_iin  = 1'b0;
      r_next.en_vsys = 1'b0;
    end

    // peak power sequence: qualify, overload, relax
    case (r_reg.pp)
      COTRP_PP_IDLE: begin
        if (trig) begin
          r_next.pp = COTRP_PP_QUAL;
        end
      end
      COTRP_PP_QUAL: begin
        if (!trig) begin
          r_next.pp = COTRP_PP_IDLE;
        end else if (pp_done) begin
          r_next.pp = COTRP_PP_OVLD;
        end
      end
      COTRP_PP_OVLD: begin
        if (pp_done) begin
          r_next.pp = COTRP_PP_RELAX;
        end else if (clr_ovld) begin
          r_next.pp = COTRP_PP_IDLE;
        end
      end
      COTRP_PP_RELAX: begin
        if (pp_done || clr_relax) begin
          r_next.pp = COTRP_PP_IDLE;
        end
      end
      default: begin
        r_next.pp = COTRP_PP_IDLE;
      end
    endcase
    if (!r_reg.en_iin && !r_reg.en_vsys) begin
      r_next.pp = COTRP_PP_IDLE;
    end

    // configurable input overcurrent: blank, off, deglitched restart
    case (r_reg.oc)
      COTRP_OC_OK: begin
        if (ioc_trip) begin
          r_next.oc = COTRP_OC_BLANK;
        end
      end
      COTRP_OC_BLANK: begin
        if (!ioc_trip) begin
          r_next.oc = COTRP_OC_OK;
        end else if (oc_done) begin
          r_next.oc = COTRP_OC_OFF;
        end
      end
      COTRP_OC_OFF: begin
        if (!r_reg.sync2[COTRP_SYN_INPUT_OC]) begin
          r_next.oc = COTRP_OC_RESUME;
        end
      end
      COTRP_OC_RESUME: begin
        if (r_reg.sync2[COTRP_SYN_INPUT_OC]) begin
          r_next.oc = COTRP_OC_OFF;
        end else if (oc_done) begin
          r_next.oc = COTRP_OC_OK;
        end
      end
      default: begin
        r_next.oc = COTRP_OC_OK;
      end
    endcase
    if (!r_reg.low[COTRP_LO_IOC_EN_BIT]) begin
      r_next.oc = COTRP_OC_OK;
    end

    // no fault latches: fixed and discharge terms follow their comparators, input overcurrent follows its off/resume states
    r_next.conv_en = !(r_reg.sync2[COTRP_SYN_FIXED]
                    || r_reg.oc == COTRP_OC_OFF
                    || r_reg.oc == COTRP_OC_RESUME
                    || doc_trip);

    if (r_reg.low[COTRP_LO_EXT_BIT]
        && (limit_setting_pin_i < input_limit_value_i)) begin
      r_next.limit = limit_setting_pin_i;
    end else begin
      r_next.limit = input_limit_value_i;
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        COTRP_LOW_OFS: begin
          r_next.rdata = r_reg.low;
        end
        COTRP_HIGH_OFS: begin
          r_next.rdata = {r_reg.deg, r_reg.en_iin, r_reg.en_vsys,
                          r_reg.pp == COTRP_PP_OVLD,
                          r_reg.pp == COTRP_PP_RELAX,
                          r_reg.tmax};
        end
        default: begin
          r_next.rdata = 8'h00;
        end
      endcase
    end

    pp_restart = r_next.pp != r_reg.pp;
    oc_restart = r_next.oc != r_reg.oc;
  end

  // ----------------------------------------------------------------
  // timer limits
  // ----------------------------------------------------------------
  always_comb begin
    pp_run = r_reg.pp != COTRP_PP_IDLE;
    if (r_reg.pp == COTRP_PP_QUAL) begin
      case (r_reg.deg)
        2'b00:   pp_limit = 32'(DEG_CYC_0);
        2'b01:   pp_limit = 32'(DEG_CYC_1);
        2'b10:   pp_limit = 32'(DEG_CYC_2);
        default: pp_limit = 32'(DEG_CYC_3);
      endcase
    end else begin
      case (r_reg.tmax)
        2'b00:   pp_limit = 32'(TMAX_CYC_0);
        2'b01:   pp_limit = 32'(TMAX_CYC_1);
        2'b10:   pp_limit = 32'(TMAX_CYC_2);
        default: pp_limit = 32'(TMAX_CYC_3);
      endcase
    end
    oc_run = (r_reg.oc == COTRP_OC_BLANK) || (r_reg.oc == COTRP_OC_RESUME);
    if (r_reg.oc == COTRP_OC_BLANK) begin
      oc_limit = 32'(IOC_BLANK_CYC);
    end else begin
      oc_limit = 32'(IOC_RESUME_CYC);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_reg         <= '0;
      r_reg.low     <= COTRP_LOW_RST;
      r_reg.deg     <= COTRP_HIGH_RST[COTRP_HI_DEG_LSB +: 2];
      r_reg.en_iin  <= COTRP_HIGH_RST[COTRP_HI_IIN_BIT];
      r_reg.en_vsys <= COTRP_HIGH_RST[COTRP_HI_VSYS_BIT];
      r_reg.tmax    <= COTRP_HIGH_RST[COTRP_HI_TMAX_LSB +: 2];
      r_reg.conv_en <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // trip levels go to the analog comparators, which do the comparing
  assign reg_rdata_o                       = r_reg.rdata;
  assign input_limit_o                     = r_reg.limit;
  assign converter_enable_o                = r_reg.conv_en;
  assign overload_cycle_o                  = r_reg.pp == COTRP_PP_OVLD;
  assign relax_cycle_o                     = r_reg.pp == COTRP_PP_RELAX;
  assign battery_monitor_direction_sel_o   = r_reg.low[COTRP_LO_MON_BIT];
  assign low_side_switch_trip_sel_o        = r_reg.low[COTRP_LO_LSW_BIT];
  assign fixed_input_trip_sel_o            = r_reg.low[COTRP_LO_FIX_BIT];
  assign input_overcurrent_level_sel_o     = r_reg.low[COTRP_LO_IOC_LVL_BIT];
  assign discharge_overcurrent_level_sel_o = r_reg.low[COTRP_LO_DOC_LVL_BIT];

endmodule : cotrp_regs

`default_nettype wire

/* verif/cotrp_regs_assertions.sv */
// checker: port-level properties of the option register pair
`default_nettype none

module cotrp_regs_assertions #(
  parameter int unsigned LIM_W = 8
) (
  input wire logic             ref_clk_i,           // clock
  input wire logic             rst_i,               // reset
  input wire logic [7:0]       reg_addr_i,          // address
  input wire logic             reg_wr_i,            // write
  input wire logic [7:0]       reg_wdata_i,         // write data
  input wire logic             fixed_input_trip_i,  // fixed trip
  input wire logic [LIM_W-1:0] input_limit_value_i, // register limit
  input wire logic [LIM_W-1:0] input_limit_o,       // limit out
  input wire logic             converter_enable_o,  // converter on
  input wire logic             overload_cycle_o,    // overload
  input wire logic             relax_cycle_o        // relax
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // two sync stages plus the output flop
  sequence s_fix_held; fixed_input_trip_i [*4]; endsequence
  sequence s_hi_wr; reg_wr_i && reg_addr_i == 8'h33; endsequence
  property p_limit; 1'b1 |=> input_limit_o <= $past(input_limit_value_i); endproperty
  property p_fixed; s_fix_held |-> !converter_enable_o; endproperty
  property p_excl; !(overload_cycle_o && relax_cycle_o); endproperty
  property p_rlx_in; $rose(relax_cycle_o) |-> $past(overload_cycle_o); endproperty
  property p_rlx_out; $fell(relax_cycle_o) |-> !overload_cycle_o; endproperty
  // a write just before entry may legally clear both enables, so skip that case
  property p_ovl_hold;
    $rose(overload_cycle_o) && !reg_wr_i && !$past(reg_wr_i) |=> overload_cycle_o;
  endproperty
  property p_ovl_clr;
    s_hi_wr ##0 (overload_cycle_o && !reg_wdata_i[3]) |=> !overload_cycle_o;
  endproperty
  property p_rlx_clr;
    s_hi_wr ##0 (relax_cycle_o && !reg_wdata_i[2]) |=> !relax_cycle_o;
  endproperty
  a_limit: assert property (p_limit) else $error("limit above register value");
  a_fixed: assert property (p_fixed) else $error("fixed trip ignored");
  a_excl: assert property (p_excl) else $error("both cycle flags set");
  a_rlx_in: assert property (p_rlx_in) else $error("relax without overload");
  a_rlx_out: assert property (p_rlx_out) else $error("relax ended into overload");
  a_ovl_hold: assert property (p_ovl_hold) else $error("overload too short");
  a_ovl_clr: assert property (p_ovl_clr) else $error("overload not cleared");
  a_rlx_clr: assert property (p_rlx_clr) else $error("relax not cleared");
endmodule : cotrp_regs_assertions

`default_nettype wire

/* verif/cotrp_host_model.sv */
// host model: byte register port master, optionally slow
`default_nettype none

module cotrp_host_model (
  input  wire logic [7:0] reg_rdata_i, // read data
  input  wire logic       ref_clk_i,   // clock
  output logic [7:0]      reg_addr_o,  // address
  output logic            reg_wr_o,    // write strobe
  output logic [7:0]      reg_wdata_o, // write data
  output logic            reg_rd_o     // read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0; // extra idle cycles before each access
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (gap + 1) @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
  endtask : wr
  // data is held until the next read, so sampling late is safe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat (gap + 1) @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    d = reg_rdata_i;
  endtask : rd
endmodule : cotrp_host_model

`default_nettype wire

/* verif/tb_cotrp_regs.sv */
// testbench: option register pair driven by the host model
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_cotrp_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEG [4] = '{4, 5, 6, 7};
  localparam int TMX [4] = '{10, 12, 14, 16};
  typedef struct packed { logic [7:0] a, d, p, v, r, l; } cotrp_row_s;
  cotrp_row_s rows [6] = '{'{8'h32, 8'h80, 8'h10, 8'h20, 8'h80, 8'h10},
    '{8'h32, 8'h7F, 8'h10, 8'h20, 8'h7F, 8'h20}, '{8'h32, 8'hD5, 8'h30, 8'h20, 8'hD5, 8'h20},
    '{8'h32, 8'h2A, 8'h30, 8'h40, 8'h2A, 8'h40}, '{8'h33, 8'hFF, 8'h05, 8'h06, 8'hF3, 8'h06},
    '{8'h34, 8'h55, 8'h05, 8'h06, 8'h00, 8'h06}};
  logic ref_clk_i = 1'b0, rst_i = 1'b1, adp = 1'b1, ovs = 1'b0, uns = 1'b0;
  logic fix = 1'b0, ioc = 1'b0, doc = 1'b0, wr, rd, conv, ovl, rlx, mon, lsw, fxs, iol, dol;
  logic [7:0] pin = 8'h00, val = 8'h00, addr, wdata, rdata, lim, rd_v;
  int fail_count = 0, tests_run = 0, cyc = 0, n;

  cotrp_host_model host_u (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
  cotrp_regs #(.DEG_CYC_0(DEG[0]), .DEG_CYC_1(DEG[1]), .DEG_CYC_2(DEG[2]), .DEG_CYC_3(DEG[3]),
    .TMAX_CYC_0(TMX[0]), .TMAX_CYC_1(TMX[1]), .TMAX_CYC_2(TMX[2]), .TMAX_CYC_3(TMX[3]),
    .IOC_BLANK_CYC(5), .IOC_RESUME_CYC(8)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .adapter_present_i(adp), .input_overshoot_i(ovs), .system_undershoot_i(uns),
    .fixed_input_trip_i(fix), .input_overcurrent_trip_i(ioc),
    .discharge_overcurrent_trip_i(doc), .limit_setting_pin_i(pin), .input_limit_value_i(val),
    .input_limit_o(lim), .converter_enable_o(conv), .overload_cycle_o(ovl),
    .relax_cycle_o(rlx), .battery_monitor_direction_sel_o(mon), .low_side_switch_trip_sel_o(lsw),
    .fixed_input_trip_sel_o(fxs), .input_overcurrent_level_sel_o(iol),
    .discharge_overcurrent_level_sel_o(dol));

  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  function automatic logic sig(input int s);
    return s == 0 ? ovl : s == 1 ? rlx : conv;
  endfunction : sig
  task automatic wt(input int s, input logic v, output int k);
    k = 0;
    #1;
    while (sig(s) !== v && k < 3000) begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
  endtask : wt
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      pin <= rows[i].p;
      val <= rows[i].v;
      host_u.wr(rows[i].a, rows[i].d);
      host_u.rd(rows[i].a, rd_v);
      `CHK(rd_v, rows[i].r)
      `CHK(lim, rows[i].l)
      if (rows[i].a == 8'h32)
        `CHK({mon, lsw, fxs, iol, dol}, {rows[i].d[6:4], rows[i].d[2], rows[i].d[0]})
    end
    rst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    host_u.gap = 3;
    host_u.rd(8'h32, rd_v);
    `CHK(rd_v, 8'hB7)
    host_u.rd(8'h33, rd_v);
    `CHK(rd_v, 8'h00)
    `CHK({conv, mon, lsw, fxs, iol, dol}, 6'b10_1111)
    host_u.gap = 0;
    for (int k = 0; k < 4; k++) begin
      host_u.wr(8'h33, {k[1:0], k[0], ~k[0], 2'b00, k[1:0]});
      ovs <= k[0];
      uns <= ~k[0];
      wt(0, 1'b1, n);
      `CHK(n inside {[DEG[k]:DEG[k] + 7]}, 1'b1)
      @(posedge ref_clk_i);
      ovs <= 1'b0;
      uns <= 1'b0;
      wt(0, 1'b0, n);
      `CHK(n inside {[TMX[k] - 2:TMX[k] + 1]}, 1'b1)
      wt(1, 1'b0, n);
      `CHK(n inside {[TMX[k] - 1:TMX[k] + 1]}, 1'b1)
    end
    host_u.wr(8'h33, 8'h20);
    uns <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    `CHK(ovl, 1'b0)
    host_u.wr(8'h33, 8'h00);
    ovs <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    `CHK(ovl, 1'b0)
    uns <= 1'b0;
    host_u.wr(8'h33, 8'h20);
    for (int j = 0; j < 2; j++) begin
      wt(j, 1'b1, n);
      @(posedge ref_clk_i);
      ovs <= 1'b0;
      host_u.wr(8'h33, 8'h20);
      @(posedge ref_clk_i);
      `CHK({ovl, rlx}, 2'b00)
      ovs <= j == 0;
    end
    host_u.wr(8'h33, 8'h30);
    adp <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    adp <= 1'b1;
    host_u.rd(8'h33, rd_v);
    `CHK(rd_v, 8'h00)
    for (int j = 0; j < 2; j++) begin
      @(posedge ref_clk_i);
      fix <= j == 0;
      doc <= j == 1;
      wt(2, 1'b0, n);
      `CHK(n inside {[2:5]}, 1'b1)
      @(posedge ref_clk_i);
      fix <= 1'b0;
      doc <= 1'b0;
      wt(2, 1'b1, n);
      `CHK(n inside {[2:5]}, 1'b1)
    end
    host_u.wr(8'h32, 8'hB5);
    doc <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    `CHK(conv, 1'b1)
    doc <= 1'b0;
    host_u.wr(8'h32, 8'hBF);
    ioc <= 1'b1;
    wt(2, 1'b0, n);
    `CHK(n inside {[5:10]}, 1'b1)
    @(posedge ref_clk_i);
    ioc <= 1'b0;
    wt(2, 1'b1, n);
    `CHK(n inside {[8:13]}, 1'b1)
    print_verdict();
  end
endmodule : tb_cotrp_regs

bind cotrp_regs cotrp_regs_assertions #(.LIM_W(LIM_W)) chk_u (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .fixed_input_trip_i(fixed_input_trip_i), .input_limit_value_i(input_limit_value_i),
  .input_limit_o(input_limit_o), .converter_enable_o(converter_enable_o),
  .overload_cycle_o(overload_cycle_o), .relax_cycle_o(relax_cycle_o));

`default_nettype wire
